// >>> hw/serial_eeprom_command_unit.sv
// Instruction decoder and sequencer of a three-wire serial EEPROM slave.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_unit
    import eeprom_cmd_pkg::*;
#(
    parameter int unsigned WRITE_CYC = TWP_CYC
) (
    input  wire logic sys_clk,       // System clock, 250 MHz.
    input  wire logic nrst,          // Power-on reset, active low.
    input  wire logic cs,            // Chip select pin.
    input  wire logic serial_clock,  // Serial clock pin.
    input  wire logic serial_in,     // Serial data in pin.
    input  wire logic width_select,  // Low: byte rows, high: word rows.
    output logic      dout,          // Serial data out.
    output logic      dout_oe        // High while dout is driven.
);
    // ------------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------------
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic [1:0] prev_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            prev_reg <= 2'h0;
        end else begin
            meta_reg <= {width_select, serial_in, serial_clock, cs};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg[1:0];
        end
    end

    wire cs_s    = sync_reg[0];
    wire din_s   = sync_reg[2];
    wire org16_s = sync_reg[3];
    wire sk_rise = sync_reg[1] && !prev_reg[1];
    wire cs_fall = !cs_s && prev_reg[0];
    wire cs_rise = cs_s && !prev_reg[0];

    // ------------------------------------------------------------------
    // Instruction shifter and decoder
    // ------------------------------------------------------------------
    state_e                 state_reg;
    state_e                 state_next;
    op_e                    op_reg;
    logic                   org16_reg;
    logic [4:0]             cnt_reg;
    logic [SR_W-1:0]        sr_reg;
    logic                   prog_en_reg;
    logic                   status_reg;
    logic [CSLOW_W-1:0]     cslow_reg;
    logic [PCNT_W-1:0]      prog_cnt_reg;
    logic [10:0]            addr_reg;
    logic [15:0]            data_reg;

    function automatic op_e decode(input logic [1:0] opc, input logic [1:0] sub);
        op_e r;
        unique case (opc)
            OPC_WRITE: r = OP_WRITE;
            OPC_READ:  r = OP_READ;
            OPC_ERASE: r = OP_ERASE;
            default: begin
                unique case (sub)
                    SUB_DISABLE:  r = OP_DISABLE;
                    SUB_FILL:     r = OP_FILL;
                    SUB_ERASEALL: r = OP_ERASEALL;
                    default:      r = OP_ENABLE;
                endcase
            end
        endcase
        return r;
    endfunction : decode

    function automatic logic [10:0] next_ptr(input logic [10:0] p, input logic o16);
        return o16 ? {1'b0, p[9:0] + 10'h001} : p + 11'h001;
    endfunction : next_ptr

    function automatic logic is_prog(input op_e op);
        return op inside {OP_WRITE, OP_ERASE, OP_ERASEALL, OP_FILL};
    endfunction : is_prog

    wire [SR_W-1:0] sr_next  = {sr_reg[SR_W-2:0], din_s};
    wire [4:0]      cnt_next = cnt_reg + 5'h01;
    wire [4:0]      hdr_len  = org16_reg ? HDR16_LEN : HDR8_LEN;
    wire [4:0]      full_len = org16_reg ? FULL16_LEN : FULL8_LEN;
    wire [1:0]      opc      = org16_reg ? sr_next[11:10] : sr_next[12:11];
    wire [1:0]      sub      = org16_reg ? sr_next[9:8] : sr_next[10:9];
    wire [10:0]     hdr_addr = org16_reg ? {1'b0, sr_next[9:0]} : sr_next[10:0];
    wire            shift_sk = sk_rise && cs_s && (state_reg == S_SHIFT);
    wire            hdr_done = shift_sk && (cnt_next == hdr_len);
    wire            full_done = shift_sk && (cnt_next == full_len);
    op_e            dec_op;
    assign dec_op = decode(opc, sub);
    wire            needs_data = (dec_op == OP_WRITE) || (dec_op == OP_FILL);
    wire            enter_read = hdr_done && (dec_op == OP_READ);
    wire            start_bit = (state_reg == S_IDLE) && cs_s && sk_rise && din_s;
    wire            cmd_end = (state_reg == S_WAIT_CS) && cs_fall;
    wire            prog_done = (prog_cnt_reg == PCNT_W'(WRITE_CYC - 1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE:    if (start_bit) state_next = S_SHIFT;
            S_SHIFT: begin
                if (!cs_s) state_next = S_IDLE;
                else if (enter_read) state_next = S_READ;
                else if (hdr_done && !needs_data) state_next = S_WAIT_CS;
                else if (full_done) state_next = S_WAIT_CS;
            end
            S_READ:    if (!cs_s) state_next = S_IDLE;
            S_WAIT_CS: begin
                if (cmd_end) begin
                    state_next = (is_prog(op_reg) && prog_en_reg) ? S_PROG : S_IDLE;
                end else if (sk_rise && cs_s) begin
                    state_next = S_IGNORE;
                end
            end
            S_IGNORE:  if (!cs_s) state_next = S_IDLE;
            S_PROG:    if (prog_done) state_next = S_IDLE;
            default:   state_next = S_IDLE;
        endcase
    end

    // Reset holds every state at standby values, so pins are ignored.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= S_IDLE;
            op_reg    <= OP_DISABLE;
            org16_reg <= 1'b0;
            cnt_reg   <= 5'h00;
            sr_reg    <= '0;
            addr_reg  <= 11'h000;
            data_reg  <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (start_bit) begin
                org16_reg <= org16_s;
                cnt_reg   <= 5'h00;
            end else if (shift_sk) begin
                cnt_reg <= cnt_next;
                sr_reg  <= sr_next;
            end
            if (hdr_done) begin
                op_reg   <= dec_op;
                addr_reg <= hdr_addr;
            end
            if (full_done) data_reg <= org16_reg ? sr_next[15:0] : {8'h00, sr_next[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // Write protection and self-timed programming
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prog_en_reg  <= 1'b0;
            prog_cnt_reg <= '0;
        end else begin
            if (cmd_end && op_reg == OP_ENABLE) prog_en_reg <= 1'b1;
            if (cmd_end && op_reg == OP_DISABLE) prog_en_reg <= 1'b0;
            prog_cnt_reg <= (state_reg == S_PROG) ? prog_cnt_reg + 21'h000001 : '0;
        end
    end

    wire             all_op   = (op_reg == OP_ERASEALL) || (op_reg == OP_FILL);
    wire             erase_op = (op_reg == OP_ERASEALL) || (op_reg == OP_ERASE);
    wire             mem_we   = (state_reg == S_PROG) &&
                                (all_op ? (prog_cnt_reg < ROWS) : (prog_cnt_reg == '0));
    wire [ROW_W-1:0] mem_waddr = all_op ? prog_cnt_reg[ROW_W-1:0] :
                                 (org16_reg ? addr_reg[9:0] : addr_reg[10:1]);
    wire [1:0]       mem_wbe  = (all_op || org16_reg) ? 2'h3 : (addr_reg[0] ? 2'h2 : 2'h1);
    wire [15:0]      mem_wdata = erase_op ? ERASED :
                                 (org16_reg ? data_reg : {data_reg[7:0], data_reg[7:0]});

    // ------------------------------------------------------------------
    // Sequential read engine
    // ------------------------------------------------------------------
    logic [10:0] ptr_reg;
    logic        lane_reg;
    logic        pend_reg;
    logic [15:0] sh_reg;
    logic [4:0]  bits_reg;
    logic        bit_reg;
    logic [15:0] mem_rdata;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic [15:0] buf_out_data;

    wire             in_read  = (state_reg == S_READ);
    wire             issue    = in_read && buf_in_ready && !pend_reg;
    wire [ROW_W-1:0] mem_raddr = org16_reg ? ptr_reg[9:0] : ptr_reg[10:1];
    wire [15:0]      buf_in_data = org16_reg ? mem_rdata :
                                   {8'h00, (lane_reg ? mem_rdata[15:8] : mem_rdata[7:0])};
    wire             read_sk  = in_read && sk_rise && cs_s;
    wire             pop      = read_sk && (bits_reg == 5'h00);
    wire [15:0]      load     = org16_reg ? buf_out_data : {buf_out_data[7:0], 8'h00};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ptr_reg  <= 11'h000;
            lane_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= issue;
            if (enter_read) ptr_reg <= hdr_addr;
            else if (issue) ptr_reg <= next_ptr(ptr_reg, org16_reg);
            if (issue) lane_reg <= ptr_reg[0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sh_reg   <= 16'h0000;
            bits_reg <= 5'h00;
            bit_reg  <= 1'b0;
        end else if (enter_read) begin
            bit_reg  <= 1'b0;
            bits_reg <= 5'h00;
        end else if (pop && buf_out_valid) begin
            bit_reg  <= load[15];
            sh_reg   <= {load[14:0], 1'b0};
            bits_reg <= org16_reg ? BITS16_LAST : BITS8_LAST;
        end else if (read_sk && bits_reg != 5'h00) begin
            bit_reg  <= sh_reg[15];
            sh_reg   <= {sh_reg[14:0], 1'b0};
            bits_reg <= bits_reg - 5'h01;
        end
    end

    eeprom_array u_array (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .we      (mem_we),
        .wbe     (mem_wbe),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata   (mem_rdata)
    );

    pair_buffer #(.W(16)) u_buffer (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .flush     (!in_read),
        .in_valid  (pend_reg && in_read),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (pop),
        .out_data  (buf_out_data)
    );

    // ------------------------------------------------------------------
    // Ready/busy status and output pin
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cslow_reg  <= '0;
            status_reg <= 1'b0;
            dout       <= 1'b0;
            dout_oe    <= 1'b0;
        end else begin
            if (cs_s) cslow_reg <= '0;
            else if (cslow_reg != CSLOW_W'(TCS_CYC)) cslow_reg <= cslow_reg + 6'h01;
            if (!cs_s || start_bit) status_reg <= 1'b0;
            else if (cs_rise && state_reg == S_PROG && cslow_reg == CSLOW_W'(TCS_CYC))
                status_reg <= 1'b1;
            dout    <= status_reg ? (state_reg != S_PROG) : bit_reg;
            dout_oe <= cs_s && (status_reg || in_read);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_cmd_end;
        (state_reg == S_WAIT_CS) && cs_fall;
    endsequence
    sequence s_read_open;
        enter_read ##1 cs_s;
    endsequence

    a_prog_start_fall: assert property (s_cmd_end ##0 (is_prog(op_reg) && prog_en_reg)
        |=> state_reg == S_PROG) else $error("programming not started");
    a_write_protect_on: assert property (s_cmd_end ##0 !prog_en_reg
        |=> state_reg != S_PROG) else $error("disabled device programmed");
    a_extra_clock_rej: assert property ((state_reg == S_WAIT_CS) && sk_rise && cs_s
        |=> state_reg == S_IGNORE) else $error("extra clock accepted");
    a_fill_length: assert property (full_done |=> (state_reg == S_WAIT_CS) &&
        (cnt_reg == (org16_reg ? 5'h1C : 5'h15))) else $error("bad data length");
    a_read_lead_zero: assert property (s_read_open |=> (dout_oe && !dout))
        else $error("no leading zero");
    a_status_busy_low: assert property (status_reg && (state_reg == S_PROG)
        |=> !dout) else $error("busy not low");
    a_status_ready_high: assert property (status_reg && (state_reg != S_PROG) && cs_s
        |=> dout && dout_oe) else $error("ready not high");
    a_no_late_status: assert property (cs_rise && (state_reg != S_PROG)
        |=> !status_reg ##1 !dout_oe) else $error("late status shown");
    a_erase_all_ones: assert property (mem_we && (op_reg == OP_ERASEALL)
        |-> (mem_wdata == 16'hFFFF) && (mem_wbe == 2'h3)) else $error("erase not ones");
    a_ptr_step_next: assert property (issue && !enter_read
        |=> ptr_reg == next_ptr($past(ptr_reg), org16_reg)) else $error("pointer stuck");
    a_hiz_cs_low: assert property ((!cs_s)[*2] |-> !dout_oe)
        else $error("dout driven while deselected");
endmodule : serial_eeprom_command_unit
`default_nettype wire

// >>> hw/eeprom_cmd_pkg.sv
// Constants, types and timing counts for the serial EEPROM command unit.
package eeprom_cmd_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int TCS_NS        = 200;
    localparam int TCS_CYC       = (TCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TWP_MS        = 5;
    localparam int TWP_CYC       = TWP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CSLOW_W       = 6;
    localparam int PCNT_W        = 21;

    // ------------------------------------------------------------------
    // Field lengths, counted in serial clocks after the start bit
    // ------------------------------------------------------------------
    localparam logic [4:0] HDR8_LEN  = 5'h0D;
    localparam logic [4:0] HDR16_LEN = 5'h0C;
    localparam logic [4:0] FULL8_LEN  = 5'h15;
    localparam logic [4:0] FULL16_LEN = 5'h1C;
    localparam logic [4:0] BITS8_LAST  = 5'h07;
    localparam logic [4:0] BITS16_LAST = 5'h0F;
    localparam int SR_W  = 28;
    localparam int ROW_W = 10;
    localparam logic [PCNT_W-1:0] ROWS = 21'h000400;
    localparam logic [15:0] ERASED = 16'hFFFF;

    // ------------------------------------------------------------------
    // Opcodes and opcode-00 sub-commands
    // ------------------------------------------------------------------
    localparam logic [1:0] OPC_SPECIAL = 2'h0;
    localparam logic [1:0] OPC_WRITE   = 2'h1;
    localparam logic [1:0] OPC_READ    = 2'h2;
    localparam logic [1:0] OPC_ERASE   = 2'h3;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_FILL    = 2'h1;
    localparam logic [1:0] SUB_ERASEALL = 2'h2;
    localparam logic [1:0] SUB_ENABLE  = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_SHIFT   = 3'b001,
        S_READ    = 3'b010,
        S_WAIT_CS = 3'b011,
        S_IGNORE  = 3'b100,
        S_PROG    = 3'b101
    } state_e;

    typedef enum logic [2:0] {
        OP_DISABLE  = 3'b000,
        OP_ENABLE   = 3'b001,
        OP_ERASEALL = 3'b010,
        OP_FILL     = 3'b011,
        OP_WRITE    = 3'b100,
        OP_READ     = 3'b101,
        OP_ERASE    = 3'b110
    } op_e;
endpackage : eeprom_cmd_pkg

// >>> hw/eeprom_array.sv
// Storage array of 1024 rows of two byte lanes with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module eeprom_array
    import eeprom_cmd_pkg::*;
(
    input  wire logic             sys_clk,  // System clock.
    input  wire logic             nrst,     // Asynchronous reset, active low.
    input  wire logic             we,       // Write strobe.
    input  wire logic [1:0]       wbe,      // Byte lane enables.
    input  wire logic [ROW_W-1:0] waddr,    // Write row.
    input  wire logic [15:0]      wdata,    // Write data.
    input  wire logic [ROW_W-1:0] raddr,    // Read row.
    output logic      [15:0]      rdata     // Registered read data.
);
    logic [15:0] mem [1024];

    always_ff @(posedge sys_clk) begin
        if (we && wbe[0]) mem[waddr][7:0] <= wdata[7:0];
        if (we && wbe[1]) mem[waddr][15:8] <= wdata[15:8];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) rdata <= 16'h0000;
        else rdata <= mem[raddr];
    end
endmodule : eeprom_array
`default_nettype wire

// >>> hw/pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,    // System clock.
    input  wire logic         nrst,       // Asynchronous reset, active low.
    input  wire logic         flush,      // Empties the buffer.
    input  wire logic         in_valid,   // Filling side offers a word.
    output logic              in_ready,   // Room for a word.
    input  wire logic [W-1:0] in_data,    // Word in.
    output logic              out_valid,  // A word is held.
    input  wire logic         out_ready,  // Draining side takes the word.
    output logic      [W-1:0] out_data    // Oldest word.
);
    logic [W-1:0] slot_reg [2];
    logic         rd_reg;
    logic         wr_reg;
    logic [1:0]   cnt_reg;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = slot_reg[rd_reg];

    always_ff @(posedge sys_clk) begin
        if (push) slot_reg[wr_reg] <= in_data;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 2'h0;
            rd_reg  <= 1'b0;
            wr_reg  <= 1'b0;
        end else if (flush) begin
            cnt_reg <= 2'h0;
            rd_reg  <= 1'b0;
            wr_reg  <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
            if (push) wr_reg <= ~wr_reg;
            if (pop) rd_reg <= ~rd_reg;
        end
    end
endmodule : pair_buffer
`default_nettype wire

// >>> bench/host_model.sv
// Host model that drives the three-wire serial link of the command unit.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic sys_clk,       // System clock.
    output logic      cs,            // Chip select.
    output logic      serial_clock,  // Serial clock, 160 ns period.
    output logic      serial_in,     // Serial data to the device.
    input  wire logic dout,          // Serial data from the device.
    input  wire logic dout_oe        // High while the device drives dout.
);
    // An undriven output reads as the inverse of its last level, so a lost enable shows.
    wire logic seen_line = dout_oe ? dout : !dout;
    initial begin
        cs           = 1'b0;
        serial_clock = 1'b0;
        serial_in    = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // The serial clock stands still once the last bit is shifted.
    task automatic send(input logic [31:0] v, input int n);
        cs <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= v[i];
            cyc(10);
            serial_clock <= 1'b1;
            cyc(20);
            serial_clock <= 1'b0;
            cyc(10);
        end
    endtask : send
    task automatic finish();
        cs        <= 1'b0;
        serial_in <= ~serial_in;
        cyc(60);
    endtask : finish
    // Raises chip select after the minimum low time and waits for ready.
    task automatic poll(output logic first, output logic oe, output logic ready);
        cs <= 1'b1;
        cyc(12);
        first = seen_line;
        oe    = dout_oe;
        ready = 1'b0;
        for (int i = 0; i < 5000 && ready !== 1'b1; i++) begin
            cyc(1);
            ready = seen_line;
        end
        finish();
    endtask : poll
    task automatic fetch(input int n, output logic lead, output logic oe,
                         output logic [31:0] d);
        lead = seen_line;
        oe   = dout_oe;
        d    = '0;
        for (int i = 0; i < n; i++) begin
            serial_in    <= ~serial_in;
            serial_clock <= 1'b1;
            cyc(12);
            d = {d[30:0], seen_line};
            cyc(8);
            serial_clock <= 1'b0;
            cyc(20);
        end
        finish();
    endtask : fetch
endmodule : host_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench of the serial EEPROM command unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eeprom_cmd_pkg::*;
    localparam int unsigned WCYC = 3000;
    logic        sys_clk, nrst, width_select, f, oe, rdy, lead;
    logic [31:0] d;
    wire logic   cs, serial_clock, serial_in, dout, dout_oe;
    int          mismatches = 0;
    int          num_checks = 0;
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    host_model host_u (.sys_clk(sys_clk), .cs(cs), .serial_clock(serial_clock),
        .serial_in(serial_in), .dout(dout), .dout_oe(dout_oe));
    serial_eeprom_command_unit #(.WRITE_CYC(WCYC)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
        .cs(cs), .serial_clock(serial_clock), .serial_in(serial_in),
        .width_select(width_select), .dout(dout), .dout_oe(dout_oe));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // A programming command must read busy first, then ready.
    task automatic cmd(input logic [31:0] v, input int n, input logic prog);
        host_u.send(v, n);
        host_u.finish();
        if (prog) begin
            host_u.poll(f, oe, rdy);
            chk({oe, f, rdy}, 32'h5);
        end
    endtask : cmd
    task automatic rd(input logic [31:0] v, input int n, input int nb, input logic [31:0] exp);
        host_u.send(v, n);
        host_u.fetch(nb, lead, oe, d);
        chk({oe, lead}, 32'h2);
        chk(d, exp);
    endtask : rd
    task automatic t_erase_all();
        width_select <= 1'b1;
        cmd(13'h13A5, 13, 1'b0);
        cmd(13'h125A, 13, 1'b1);
        rd(13'h1BFF, 13, 32, 32'hFFFFFFFF);
    endtask : t_erase_all
    task automatic t_protect();
        cmd({13'h1155, 16'h1E87}, 29, 1'b1);
        cmd({13'h1405, 16'hA5C3}, 29, 1'b1);
        cmd(13'h10C3, 13, 1'b0);
        cmd({13'h1405, 16'h1234}, 29, 1'b0);
        rd(13'h1805, 13, 32, 32'hA5C31E87);
    endtask : t_protect
    task automatic t_late_raise();
        cmd(13'h13A5, 13, 1'b0);
        host_u.send(13'h1C05, 13);
        host_u.finish();
        host_u.cyc(WCYC + 200);
        host_u.poll(f, oe, rdy);
        chk(oe, 1'b0);
        rd(13'h1805, 13, 16, 32'hFFFF);
    endtask : t_late_raise
    task automatic t_byte_fill();
        width_select <= 1'b0;
        host_u.cyc(2);
        cmd(14'h26A5, 14, 1'b0);
        cmd(15'h4000, 15, 1'b0);
        cmd({14'h23FF, 8'h3C}, 22, 1'b1);
        rd(14'h37FF, 14, 16, 32'h3C3C);
        cmd({14'h2FFF, 8'h5A}, 22, 1'b1);
        rd(14'h37FE, 14, 16, 32'h3C5A);
    endtask : t_byte_fill
    task automatic t_second_reset();
        nrst <= 1'b0;
        host_u.cyc(3);
        chk(dout_oe, 1'b0);
        nrst <= 1'b1;
        host_u.cyc(4);
        cmd(14'h3801, 14, 1'b0);
        cmd(14'h26A5, 14, 1'b0);
        cmd(14'h3800, 14, 1'b1);
        rd(14'h3000, 14, 16, 32'hFF3C);
    endtask : t_second_reset
    initial begin
        nrst         = 1'b0;
        width_select = 1'b1;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        host_u.cyc(4);
        chk(dout_oe, 1'b0);
        t_erase_all();
        t_protect();
        t_late_raise();
        t_byte_fill();
        t_second_reset();
        tally_and_finish();
    end
    initial begin
        repeat (80000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
